// ---- rmcd_pkg.sv ----
// package: register map constants, command codes and carrier structs
package rmcd_pkg;

    // register numbers equal message addresses, no offset applied
    localparam logic [15:0] CMD_REG_ADDR   = 16'h0046; // 70
    localparam logic [15:0] CMD2_REG_ADDR  = 16'h0047; // 71, pulse count
    localparam logic [15:0] CMD_REG_RESET  = 16'h0000;

    // block start and end registers
    localparam logic [15:0] BLK_SYSCFG     = 16'd1000;
    localparam logic [15:0] BLK_COMMS      = 16'd1100;
    localparam logic [15:0] BLK_RTC        = 16'd1200;
    localparam logic [15:0] BLK_POWER      = 16'd1300;
    localparam logic [15:0] BLK_ARCCFG     = 16'd1400;
    localparam logic [15:0] BLK_TURB1      = 16'd2000;
    localparam logic [15:0] BLK_TURB2      = 16'd2100;
    localparam logic [15:0] BLK_TURB2_END  = 16'd2200;
    localparam logic [15:0] BLK_SP         = 16'd2200;
    localparam logic [15:0] BLK_RTD        = 16'd2300;
    localparam logic [15:0] BLK_DP         = 16'd2400;
    localparam logic [15:0] BLK_AI1        = 16'd2500;
    localparam logic [15:0] BLK_AI_END     = 16'd2700;
    localparam logic [15:0] BLK_DIN        = 16'd2900;
    localparam logic [15:0] BLK_FLOW1      = 16'd3000;
    localparam logic [15:0] BLK_FRALM      = 16'd3600;
    localparam logic [15:0] BLK_OUTCFG     = 16'd4000;
    localparam logic [15:0] BLK_HOLD32     = 16'd7000;
    localparam logic [15:0] BLK_ARC32      = 16'd7400;
    localparam logic [15:0] BLK_HOLD16     = 16'd8000;
    localparam logic [15:0] BLK_ARC16      = 16'd8800;
    localparam logic [15:0] BLK_UPTR       = 16'd9000;
    localparam logic [15:0] BLK_UHOLD      = 16'd9100;
    localparam logic [15:0] BLK_STATUS     = 16'd9900;
    localparam logic [15:0] BLK_STATUS_END = 16'd10000;

    // message limits and function codes
    localparam logic [7:0] MAX_DATA_BYTES = 8'd250;
    localparam logic [7:0] MAX_REGS16     = 8'd125;
    localparam logic [7:0] MAX_REGS32     = 8'd62;
    localparam logic [7:0] FN_READ_HOLD   = 8'h03;
    localparam logic [7:0] FN_PRESET_MULT = 8'h10;

    // command codes
    localparam logic [15:0] CC_POLL_ROLL   = 16'd20000;
    localparam logic [15:0] CC_CLR_ALLTOT  = 16'd30000;
    localparam logic [15:0] CC_CLR_FR1TOT  = 16'd30001;
    localparam logic [15:0] CC_CLR_T1TOT   = 16'd30003;
    localparam logic [15:0] CC_CLR_T2TOT   = 16'd30004;
    localparam logic [15:0] CC_CLR_ALLLAT  = 16'd30050;
    localparam logic [15:0] CC_CLR_PO1LAT  = 16'd30051;
    localparam logic [15:0] CC_ADD_PULSES  = 16'd30061;
    localparam logic [15:0] CC_CLR_ALLALM  = 16'd30100;
    localparam logic [15:0] CC_CLR_FRALM   = 16'd30101;
    localparam logic [15:0] CC_CLR_INALM   = 16'd30102;
    localparam logic [15:0] CC_DEFAULTS    = 16'd40000;
    localparam logic [15:0] CC_RESTART     = 16'd40040;
    localparam logic [15:0] CC_ARCHIVE     = 16'd50050;

    // functional map blocks
    typedef enum logic [4:0] {
        RMCD_BLK_NONE, RMCD_BLK_CTRL, RMCD_BLK_SYSCFG, RMCD_BLK_COMMS,
        RMCD_BLK_RTC, RMCD_BLK_POWER, RMCD_BLK_ARCCFG, RMCD_BLK_TURB1,
        RMCD_BLK_TURB2, RMCD_BLK_SP, RMCD_BLK_RTD, RMCD_BLK_DP,
        RMCD_BLK_AI, RMCD_BLK_DIN, RMCD_BLK_FLOW1, RMCD_BLK_FRALM,
        RMCD_BLK_OUTCFG, RMCD_BLK_HOLD32, RMCD_BLK_ARC32, RMCD_BLK_HOLD16,
        RMCD_BLK_ARC16, RMCD_BLK_UPTR, RMCD_BLK_UHOLD, RMCD_BLK_STATUS
    } rmcd_block_e;

    // register access from the protocol engine
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rmcd_access_s;

    // one-cycle action strobes toward the measurement core
    typedef struct packed {
        logic pollRoll;
        logic clrFlowRun1Tot;
        logic clrTurb1Tot;
        logic clrTurb2Tot;
        logic clrPulseOut1Latch;
        logic clrOtherLatches;
        logic addPulses;
        logic clrFlowRunAlarm;
        logic clrInputAlarm;
        logic clrOtherAlarms;
        logic loadDefaults;
        logic restart;
        logic archiveRecord;
    } rmcd_action_s;

endpackage : rmcd_pkg

// ---- rmcd_block_decode.sv ----
// file: address to functional map block decoder
`timescale 1ns/100ps
module rmcd_block_decode (
    // address in
    input  wire logic [15:0]          addr,
    input  wire logic                 wiredBuild,
    // decoded block
    output rmcd_pkg::rmcd_block_e     block
);
    import rmcd_pkg::*;

    // range check used for every ranged block except UHOLD, which compares inline
    function automatic logic inRange(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        inRange = (a >= lo) && (a < hi);
    endfunction : inRange

    // priority walk of start registers, highest first
    always_comb begin
        block = RMCD_BLK_NONE;
        if (addr == CMD_REG_ADDR || addr == CMD2_REG_ADDR) begin
            block = RMCD_BLK_CTRL;
        end else if (inRange(addr, BLK_STATUS, BLK_STATUS_END)) begin
            block = RMCD_BLK_STATUS;
        end else if (addr >= BLK_UHOLD && addr < BLK_STATUS) begin
            block = RMCD_BLK_UHOLD;
        end else if (inRange(addr, BLK_UPTR, BLK_UHOLD)) begin
            block = RMCD_BLK_UPTR;
        end else if (inRange(addr, BLK_ARC16, BLK_UPTR)) begin
            block = RMCD_BLK_ARC16;
        end else if (inRange(addr, BLK_HOLD16, BLK_ARC16)) begin
            block = RMCD_BLK_HOLD16;
        end else if (inRange(addr, BLK_ARC32, BLK_HOLD16)) begin
            block = RMCD_BLK_ARC32;
        end else if (inRange(addr, BLK_HOLD32, BLK_ARC32)) begin
            block = RMCD_BLK_HOLD32;
        end else if (inRange(addr, BLK_OUTCFG, BLK_HOLD32)) begin
            block = RMCD_BLK_OUTCFG;
        end else if (inRange(addr, BLK_FRALM, BLK_OUTCFG)) begin
            block = RMCD_BLK_FRALM;
        end else if (inRange(addr, BLK_FLOW1, BLK_FRALM)) begin
            block = RMCD_BLK_FLOW1;
        end else if (inRange(addr, BLK_DIN, BLK_FLOW1)) begin
            block = RMCD_BLK_DIN;
        end else if (inRange(addr, BLK_AI1, BLK_AI_END)) begin
            // analog inputs exist only in the wired build
            block = wiredBuild ? RMCD_BLK_AI : RMCD_BLK_NONE;
        end else if (inRange(addr, BLK_DP, BLK_AI1)) begin
            block = RMCD_BLK_DP;
        end else if (inRange(addr, BLK_RTD, BLK_DP)) begin
            block = RMCD_BLK_RTD;
        end else if (inRange(addr, BLK_SP, BLK_RTD)) begin
            block = RMCD_BLK_SP;
        end else if (inRange(addr, BLK_TURB2, BLK_TURB2_END)) begin
            block = wiredBuild ? RMCD_BLK_TURB2 : RMCD_BLK_NONE;
        end else if (inRange(addr, BLK_TURB1, BLK_TURB2)) begin
            block = RMCD_BLK_TURB1;
        end else if (inRange(addr, BLK_ARCCFG, BLK_TURB1)) begin
            block = RMCD_BLK_ARCCFG;
        end else if (inRange(addr, BLK_POWER, BLK_ARCCFG)) begin
            block = RMCD_BLK_POWER;
        end else if (inRange(addr, BLK_RTC, BLK_POWER)) begin
            block = RMCD_BLK_RTC;
        end else if (inRange(addr, BLK_COMMS, BLK_RTC)) begin
            block = RMCD_BLK_COMMS;
        end else if (inRange(addr, BLK_SYSCFG, BLK_COMMS)) begin
            block = RMCD_BLK_SYSCFG;
        end
    end

endmodule : rmcd_block_decode

// ---- rmcd_register_map_command_decoder.sv ----
// file: top of the register map and command trigger decoder
`timescale 1ns/100ps
module rmcd_register_map_command_decoder (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // build option
    input  wire logic                 wiredBuild,
    // register access from the protocol engine, answer from the map blocks
    input  rmcd_pkg::rmcd_access_s    access,
    input  wire logic [15:0]          blockRdata,
    input  wire logic                 blockReadOnly,
    // register answer
    output logic [15:0]               rdata,
    output logic                      rvalid,
    output logic                      illegalAddr,
    // routed write toward the map blocks
    output rmcd_pkg::rmcd_block_e     block,
    output logic                      blockWr,
    output logic [15:0]               blockAddr,
    output logic [15:0]               blockWdata,
    // command actions
    output rmcd_pkg::rmcd_action_s    action,
    output logic [15:0]               pulseCount,
    output logic [15:0]               pollIndex
);
    import rmcd_pkg::*;

    rmcd_block_e  decBlock;
    logic [15:0]  cmd_reg;
    logic [15:0]  cmd2_reg;
    logic [15:0]  pollIndex_reg;
    logic         cmdWr;
    logic         known;
    rmcd_action_s action_next;

    // address is used as the register number with no offset
    rmcd_block_decode u_decode (
        .addr       (access.addr),
        .wiredBuild (wiredBuild),
        .block      (decBlock)
    );

    // one compare for a single command code, used only by the poll roll and pulse add registers
    function automatic logic isCode(input rmcd_access_s acc,
                                    input logic [15:0]  code);
        isCode = acc.wr && acc.addr == CMD_REG_ADDR && acc.wdata == code;
    endfunction : isCode

    // register write seen at one control address
    function automatic logic ctrlWrite(input rmcd_access_s acc,
                                       input logic [15:0]  where);
        ctrlWrite = acc.wr && acc.addr == where;
    endfunction : ctrlWrite

    // command write only when the command register is addressed, not the pulse count register
    assign cmdWr = ctrlWrite(access, CMD_REG_ADDR);

    // command register, read-write, holds the last code written
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_reg <= CMD_REG_RESET;
        end else if (cmdWr) begin
            cmd_reg <= access.wdata;
        end
    end

    // second command register carries the count for the add code
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd2_reg <= CMD_REG_RESET;
        end else if (ctrlWrite(access, CMD2_REG_ADDR)) begin
            cmd2_reg <= access.wdata;
        end
    end

    // code decode: one strobe set per write, unknown code gives none
    always_comb begin
        action_next = '0;
        known       = 1'b1;
        unique case (access.wdata)
            CC_POLL_ROLL:  action_next.pollRoll = 1'b1;
            CC_CLR_ALLTOT: begin
                action_next.clrFlowRun1Tot = 1'b1;
                action_next.clrTurb1Tot    = 1'b1;
                action_next.clrTurb2Tot    = wiredBuild;
            end
            CC_CLR_FR1TOT: action_next.clrFlowRun1Tot = 1'b1;
            CC_CLR_T1TOT:  action_next.clrTurb1Tot    = 1'b1;
            CC_CLR_T2TOT:  action_next.clrTurb2Tot = wiredBuild;
            CC_CLR_ALLLAT: begin
                action_next.clrPulseOut1Latch = 1'b1;
                action_next.clrOtherLatches   = 1'b1;
            end
            CC_CLR_PO1LAT: action_next.clrPulseOut1Latch = 1'b1;
            CC_ADD_PULSES: action_next.addPulses = 1'b1;
            CC_CLR_ALLALM: begin
                action_next.clrFlowRunAlarm = 1'b1;
                action_next.clrInputAlarm   = 1'b1;
                action_next.clrOtherAlarms  = 1'b1;
            end
            CC_CLR_FRALM:  action_next.clrFlowRunAlarm = 1'b1;
            CC_CLR_INALM:  action_next.clrInputAlarm   = 1'b1;
            CC_DEFAULTS:   action_next.loadDefaults    = 1'b1;
            CC_RESTART:    action_next.restart         = 1'b1;
            CC_ARCHIVE:    action_next.archiveRecord   = 1'b1;
            default:       known = 1'b0;
        endcase
    end

    // strobes last exactly one cycle per accepted write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            action <= '0;
        end else begin
            action <= (cmdWr && known) ? action_next : '0;
        end
    end

    // pulse count presented with the add strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulseCount <= 16'h0000;
        end else if (isCode(access, CC_ADD_PULSES)) begin
            pulseCount <= cmd2_reg;
        end
    end

    // polling index steps on every roll; wraps silently at 16 bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pollIndex_reg <= 16'h0000;
        end else if (isCode(access, CC_POLL_ROLL)) begin
            pollIndex_reg <= pollIndex_reg + 16'h0001;
        end
    end
    assign pollIndex = pollIndex_reg;

    // routed write strobe: read-only targets, absent blocks and the
    // control words drop it, so the map never sees a command twice
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blockWr <= 1'b0;
        end else begin
            blockWr <= access.wr && !blockReadOnly
                       && decBlock != RMCD_BLK_NONE
                       && decBlock != RMCD_BLK_CTRL;
        end
    end

    // copies of the routed access; kept even when the strobe is dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            block      <= RMCD_BLK_NONE;
            blockAddr  <= 16'h0000;
            blockWdata <= 16'h0000;
        end else begin
            block      <= decBlock;
            blockAddr  <= access.addr;
            blockWdata <= access.wdata;
        end
    end

    // one answer per register: a full message is the engine's run of
    // single reads, one per cycle, and nothing is buffered here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= access.rd;
        end
    end

    // unmapped or absent addresses are flagged for reads and writes alike
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            illegalAddr <= 1'b0;
        end else begin
            illegalAddr <= (access.rd || access.wr)
                           && decBlock == RMCD_BLK_NONE;
        end
    end

    // read data: control words read back, unmapped reads give zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else if (access.rd) begin
            if (access.addr == CMD_REG_ADDR) begin
                rdata <= cmd_reg;
            end else if (access.addr == CMD2_REG_ADDR) begin
                rdata <= cmd2_reg;
            end else if (decBlock == RMCD_BLK_NONE) begin
                rdata <= 16'h0000;
            end else begin
                rdata <= blockRdata;
            end
        end
    end

endmodule : rmcd_register_map_command_decoder

// ---- rmcd_properties.sv ----
// checker: port-level properties of the map and command decoder
`timescale 1ns/100ps
module rmcd_properties (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // watched inputs
    input wire logic                 wiredBuild,
    input rmcd_pkg::rmcd_access_s    access,
    input wire logic                 blockReadOnly,
    // watched outputs
    input wire logic [15:0]          rdata,
    input wire logic                 rvalid,
    input wire logic                 illegalAddr,
    input wire logic                 blockWr,
    input wire logic [15:0]          blockAddr,
    input rmcd_pkg::rmcd_action_s    action,
    input wire logic [15:0]          pulseCount
);
    import rmcd_pkg::*;
    logic [15:0] countReg;
    logic        cmdWr;
    // command register write seen at the ports
    assign cmdWr = access.wr && access.addr == CMD_REG_ADDR;
    // shadow of the pulse count register, so a stale count shows up
    always_ff @(posedge clk) begin
        if (sys_rst)
            countReg <= 16'h0000;
        else if (access.wr && access.addr == CMD2_REG_ADDR)
            countReg <= access.wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // archive code written at the command register
    sequence archive_req;
        cmdWr && access.wdata == CC_ARCHIVE;
    endsequence
    // a lone archive write; a repeat on the next edge fires again
    sequence archive_lone;
        archive_req ##1 !(cmdWr && access.wdata == CC_ARCHIVE);
    endsequence
    // strobe raised once, then dropped
    sequence archive_once;
        action.archiveRecord ##1 !action.archiveRecord;
    endsequence
    ro_write_dropped_a: assert property (
        access.wr && blockReadOnly |=> !blockWr)
        else $error("write to read-only register was routed");
    rw_write_routed_a: assert property (
        access.wr && !blockReadOnly && wiredBuild && access.addr == BLK_RTC
        |=> blockWr && blockAddr == $past(access.addr))
        else $error("read-write write not routed with its address");
    turb2_absent_a: assert property (
        access.rd && !wiredBuild && access.addr >= BLK_TURB2
        && access.addr < BLK_TURB2_END |=> illegalAddr)
        else $error("absent block answered in wireless build");
    cmd_read_a: assert property (
        access.rd && access.addr == CMD_REG_ADDR |=> rvalid)
        else $error("command register read gave no answer");
    unknown_quiet_a: assert property (
        cmdWr && access.wdata == 16'h3039 |=> action == '0)
        else $error("unknown code fired an action");
    archive_once_a: assert property (
        archive_lone |-> archive_once)
        else $error("archive strobe not a single pulse");
    pulse_count_a: assert property (
        action.addPulses |-> pulseCount == countReg)
        else $error("pulse count differs from second command register");
    wireless_t2_a: assert property (
        cmdWr && access.wdata == CC_CLR_T2TOT && !wiredBuild
        |=> !action.clrTurb2Tot)
        else $error("turbine 2 clear fired in wireless build");
    unmapped_zero_a: assert property (
        $past(access.rd) && illegalAddr |-> rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");
    clear_all_a: assert property (
        cmdWr && access.wdata == CC_CLR_ALLTOT && wiredBuild
        |=> action.clrFlowRun1Tot && action.clrTurb1Tot
            && action.clrTurb2Tot)
        else $error("clear all totals missed a strobe");
endmodule : rmcd_properties

bind rmcd_register_map_command_decoder rmcd_properties rmcd_properties_i (
    .clk(clk), .sys_rst(sys_rst), .wiredBuild(wiredBuild), .access(access),
    .blockReadOnly(blockReadOnly), .rdata(rdata), .rvalid(rvalid),
    .illegalAddr(illegalAddr), .blockWr(blockWr), .blockAddr(blockAddr),
    .action(action), .pulseCount(pulseCount));

// ---- rmcd_map_model.sv ----
// partner: map blocks answering routed accesses
`timescale 1ns/100ps
module rmcd_map_model (
    // access as the protocol engine presents it
    input rmcd_pkg::rmcd_access_s    access,
    // answer of the map blocks
    output logic [15:0]              blockRdata,
    output logic                     blockReadOnly
);
    import rmcd_pkg::*;
    // system configuration block is read-only throughout
    assign blockReadOnly = access.addr >= BLK_SYSCFG
                           && access.addr < BLK_COMMS;
    // data tagged by address so a misroute shows; idle bus shows the inverse
    assign blockRdata = access.rd ? access.addr ^ 16'ha5a5
                                  : ~(access.addr ^ 16'ha5a5);
endmodule : rmcd_map_model

// ---- rmcd_register_map_command_decoder_bench.sv ----
// bench: command table, map routing and reset of the decoder
`timescale 1ns/100ps
module rmcd_register_map_command_decoder_bench;
    import rmcd_pkg::*;
    typedef struct packed {
        logic        wired;
        logic [15:0] code;
        logic [12:0] act;
    } rmcd_row_s;
    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         wiredBuild = 1'b1;
    rmcd_access_s access = '0;
    logic [15:0]  blockRdata, rdata, blockAddr, blockWdata;
    logic [15:0]  pulseCount, pollIndex;
    logic         blockReadOnly, rvalid, illegalAddr, blockWr;
    rmcd_block_e  block;
    rmcd_action_s action;
    int           badCount = 0;
    int           numChecks = 0;
    int           cycles = 0;
    // one row per case: build, code, expected strobes
    rmcd_row_s rows [16] = '{
        '{1'b1, CC_POLL_ROLL, 13'h1000}, '{1'b1, CC_CLR_ALLTOT, 13'h0e00},
        '{1'b1, CC_CLR_FR1TOT, 13'h0800}, '{1'b1, CC_CLR_T1TOT, 13'h0400},
        '{1'b1, CC_CLR_T2TOT, 13'h0200}, '{1'b1, CC_CLR_ALLLAT, 13'h0180},
        '{1'b1, CC_CLR_PO1LAT, 13'h0100}, '{1'b1, CC_ADD_PULSES, 13'h0040},
        '{1'b1, CC_CLR_ALLALM, 13'h0038}, '{1'b1, CC_CLR_FRALM, 13'h0020},
        '{1'b1, CC_CLR_INALM, 13'h0010}, '{1'b1, CC_DEFAULTS, 13'h0004},
        '{1'b1, CC_RESTART, 13'h0002}, '{1'b1, CC_ARCHIVE, 13'h0001},
        '{1'b1, 16'h3039, 13'h0000}, '{1'b0, CC_CLR_T2TOT, 13'h0000}};

    // 50 ns period
    always #25 clk = ~clk;

    rmcd_register_map_command_decoder rmcd_register_map_command_decoder_i (
        .clk(clk), .sys_rst(sys_rst), .wiredBuild(wiredBuild), .access(access),
        .blockRdata(blockRdata), .blockReadOnly(blockReadOnly), .rdata(rdata),
        .rvalid(rvalid), .illegalAddr(illegalAddr), .block(block),
        .blockWr(blockWr), .blockAddr(blockAddr), .blockWdata(blockWdata),
        .action(action), .pulseCount(pulseCount), .pollIndex(pollIndex));

    rmcd_map_model rmcd_map_model_i (.access(access), .blockRdata(blockRdata),
        .blockReadOnly(blockReadOnly));

    // inputs move 1 ns after the edge so sampling never races
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one request taken at the next edge; it stands until the next call
    // replaces it or idle drops it, so no signal moves twice in a step
    task automatic op(input logic rd, input logic wr, input logic [15:0] a,
                      input logic [15:0] d);
        access = '{rd, wr, a, d};
        step;
    endtask : op

    // bus released for one edge
    task automatic idle;
        access = '0;
        step;
    endtask : idle

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            badCount++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (20) step;
        sys_rst = 1'b0;
        chk(rdata, 16'h0000);
        chk(pollIndex, 16'h0000);
        chk({3'h0, action}, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            wiredBuild = rows[i].wired;
            op(1'b0, 1'b1, CMD_REG_ADDR, rows[i].code);
            chk(16'(action[12:7]), 16'(rows[i].act[12:7]));
            chk(16'(action[6:0]), 16'(rows[i].act[6:0]));
            chk({15'h0, blockWr}, 16'h0000);
            idle;
            chk({3'h0, action}, 16'h0000);
            op(1'b1, 1'b0, CMD_REG_ADDR, 16'h0000);
            chk({15'h0, rvalid}, 16'h0001);
            chk(rdata, rows[i].code);
        end
        wiredBuild = 1'b1;
        chk(pollIndex, 16'h0001);
        $display("test command table done");
        op(1'b0, 1'b1, CMD2_REG_ADDR, 16'h1234);
        op(1'b0, 1'b1, CMD_REG_ADDR, CC_ADD_PULSES);
        chk(pulseCount, 16'h1234);
        $display("test pulse add done");
        op(1'b0, 1'b1, 16'd1000, 16'hbeef);
        chk({15'h0, blockWr}, 16'h0000);
        op(1'b0, 1'b1, BLK_RTC, 16'h0017);
        chk({15'h0, blockWr}, 16'h0001);
        chk(blockAddr, 16'h04b0);
        chk(blockWdata, 16'h0017);
        // back to back reads of both holding views
        access = '{1'b1, 1'b0, BLK_HOLD16, 16'h0000};
        step;
        access = '{1'b1, 1'b0, BLK_HOLD32, 16'h0000};
        chk(rdata, 16'h1f40 ^ 16'ha5a5);
        chk({11'h0, block}, {11'h0, RMCD_BLK_HOLD16});
        step;
        chk(rdata, BLK_HOLD32 ^ 16'ha5a5);
        chk({11'h0, block}, {11'h0, RMCD_BLK_HOLD32});
        // a full message of single reads, one register per edge
        for (int n = 0; n < MAX_REGS16; n++) begin
            op(1'b1, 1'b0, BLK_HOLD16 + 16'(n), 16'h0000);
            chk(rdata, (BLK_HOLD16 + 16'(n)) ^ 16'ha5a5);
        end
        op(1'b1, 1'b0, 16'h0010, 16'h0000);
        chk({15'h0, illegalAddr}, 16'h0001);
        chk(rdata, 16'h0000);
        op(1'b1, 1'b0, 16'd2630, 16'h0000);
        chk({15'h0, illegalAddr}, 16'h0000);
        chk({11'h0, block}, {11'h0, RMCD_BLK_AI});
        wiredBuild = 1'b0;
        op(1'b1, 1'b0, 16'd2630, 16'h0000);
        chk({15'h0, illegalAddr}, 16'h0001);
        op(1'b1, 1'b0, BLK_TURB2, 16'h0000);
        chk({15'h0, illegalAddr}, 16'h0001);
        op(1'b0, 1'b1, CMD_REG_ADDR, CC_CLR_ALLTOT);
        chk({3'h0, action}, 16'h0c00);
        $display("test map routing done");
        sys_rst = 1'b1;
        idle;
        sys_rst = 1'b0;
        op(1'b1, 1'b0, CMD_REG_ADDR, 16'h0000);
        chk(rdata, 16'h0000);
        chk(pollIndex, 16'h0000);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule : rmcd_register_map_command_decoder_bench
